// ===== uls_line_status.sv
// Receive line status flags, receive buffer and register file on classic Wishbone
//
// What this block does
// R1 - Data-ready bit 0 is high while the receive buffer holds an unread character.
// R2 - Overrun bit 1 sets on the clock edge ending the overrun cycle, so it reads high from the next cycle.
// R3 - Reading the line status register clears the overrun bit.
// R4 - Overrun means a new character completed while the receive buffer was full.
// R5 - On overrun the buffer is kept and the new character is dropped.
// R6 - Parity bit 2 sets when the received parity bit has the wrong state.
// R7 - Reading the line status register clears the parity bit.
// R8 - Parity error belongs to the character at the head of the buffer.
// R9 - FIFO-enable decides when the parity error is flagged.
// R10 - Line status sits at 0xE000C014, read only; writes change nothing.
// R11 - FIFO-enable turns on both receive and transmit FIFOs.
// R12 - Parity is checked only while parity checking is enabled.
// R13 - After reset data-ready, overrun and parity bits read zero.
`timescale 1ns/100ps
`include "uls_map.svh"
module uls_line_status (
  input wire logic ref_clk,
  input wire logic rst,
  input uls_pkg::uls_wb_req_t wb_req,
  output uls_pkg::uls_wb_rsp_t wb_rsp,
  input uls_pkg::uls_rx_char_t rx_char,
  output uls_pkg::uls_line_ctrl_t line_ctrl,
  output uls_pkg::uls_fifo_ctrl_t fifo_ctrl,
  output logic irq
);
  import uls_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic req;
  logic bus_rd;
  logic bus_wr;
  logic lane0_wr;
  logic hit_lsr;
  logic hit_fcr;
  logic hit_lcr;
  logic hit_rbr;
  logic hit_isr;
  logic hit_mask;
  uls_line_ctrl_t line_ctrl_reg;
  logic fifo_en_reg;
  logic [1:0] trigger_reg;
  logic tx_reset_reg;
  logic rx_flush_reg;
  logic [`ULS_INT_W-1:0] int_mask_reg;
  logic [`ULS_INT_W-1:0] int_status;
  logic [`ULS_INT_W-1:0] int_event;
  logic irq_reg;
  logic lsr_read;
  logic rbr_read;
  logic isr_read;
  logic [7:0] len_mask;
  logic data_ones;
  logic parity_bad;
  logic fifo_full;
  logic fifo_empty;
  logic [`ULS_CNT_W-1:0] fifo_count;
  uls_rx_entry_t fifo_head;
  uls_rx_entry_t push_entry;
  logic push_ok;
  logic overrun_event;
  logic head_new_reg;
  logic head_new_next;
  logic parity_event;
  logic overrun_flag;
  logic parity_error_flag;
  logic rx_data_ready;
  logic [7:0] line_status_reg;
  logic [`ULS_CNT_W-1:0] trig_level;
  logic level_hit;
  logic level_hit_reg;

  // --------------------------------------------------------------------------
  // Wishbone slave decode
  // --------------------------------------------------------------------------
  // Every access is answered one cycle after it is seen; unmapped reads give zero
  assign req = wb_req.cyc && wb_req.stb && !ack_reg;
  assign bus_rd = req && !wb_req.we;
  assign bus_wr = req && wb_req.we;
  assign lane0_wr = bus_wr && wb_req.sel[`ULS_WB_LANE0];
  assign hit_lsr = (wb_req.adr == `ULS_ADDR_LINE_STATUS);
  assign hit_fcr = (wb_req.adr == `ULS_ADDR_FIFO_CTRL);
  assign hit_lcr = (wb_req.adr == `ULS_ADDR_LINE_CTRL);
  assign hit_rbr = (wb_req.adr == `ULS_ADDR_RX_BUFFER);
  assign hit_isr = (wb_req.adr == `ULS_ADDR_INT_STATUS);
  assign hit_mask = (wb_req.adr == `ULS_ADDR_INT_MASK);
  assign lsr_read = bus_rd && hit_lsr;
  assign rbr_read = bus_rd && hit_rbr;
  assign isr_read = bus_rd && hit_isr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_comb begin
    rd_data_next = `ULS_DATA_ZERO;
    if (hit_lsr) begin
      rd_data_next[7:0] = line_status_reg;
    end else if (hit_lcr) begin
      rd_data_next[7:0] = line_ctrl_reg;
    end else if (hit_fcr) begin
      rd_data_next[`ULS_FCR_ENABLE] = fifo_en_reg;
      rd_data_next[`ULS_FCR_TRIG_HI:`ULS_FCR_TRIG_LO] = trigger_reg;
    end else if (hit_rbr) begin
      rd_data_next[7:0] = fifo_empty ? 8'h00 : fifo_head.data;
    end else if (hit_isr) begin
      rd_data_next[`ULS_INT_W-1:0] = int_status;
    end else if (hit_mask) begin
      rd_data_next[`ULS_INT_W-1:0] = int_mask_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_reg <= `ULS_DATA_ZERO;
    end else if (bus_rd) begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign wb_rsp = '{ack: ack_reg, dat: rd_data_reg};

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_ctrl_reg <= `ULS_LCR_RST;
    end else if (lane0_wr && hit_lcr) begin
      line_ctrl_reg <= wb_req.dat[7:0];
    end
  end

  // Toggling the enable empties both FIFOs, so stale bytes never mix modes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {fifo_en_reg, trigger_reg} <= `ULS_FCR_RST;
      rx_flush_reg <= 1'b0;
      tx_reset_reg <= 1'b0;
    end else begin
      rx_flush_reg <= 1'b0;
      tx_reset_reg <= 1'b0;
      if (lane0_wr && hit_fcr) begin
        fifo_en_reg <= wb_req.dat[`ULS_FCR_ENABLE]; // R11
        trigger_reg <= wb_req.dat[`ULS_FCR_TRIG_HI:`ULS_FCR_TRIG_LO];
        rx_flush_reg <= wb_req.dat[`ULS_FCR_RX_RESET] ||
                        (wb_req.dat[`ULS_FCR_ENABLE] != fifo_en_reg); // R11
        tx_reset_reg <= wb_req.dat[`ULS_FCR_TX_RESET] ||
                        (wb_req.dat[`ULS_FCR_ENABLE] != fifo_en_reg); // R11
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_mask_reg <= `ULS_MASK_RST;
    end else if (lane0_wr && hit_mask) begin
      int_mask_reg <= wb_req.dat[`ULS_INT_W-1:0];
    end
  end

  assign line_ctrl = line_ctrl_reg;
  assign fifo_ctrl = '{trigger: trigger_reg,
                       fifo_enable: fifo_en_reg, // R11
                       tx_fifo_reset: tx_reset_reg};

  // --------------------------------------------------------------------------
  // Parity check of an arriving character
  // --------------------------------------------------------------------------
  always_comb begin
    len_mask = 8'hFF;
    unique case (line_ctrl_reg.word_len)
      ULS_LEN5: len_mask = 8'h1F;
      ULS_LEN6: len_mask = 8'h3F;
      ULS_LEN7: len_mask = 8'h7F;
      ULS_LEN8: len_mask = 8'hFF;
    endcase
  end

  assign data_ones = ^(rx_char.data & len_mask);

  always_comb begin
    parity_bad = 1'b0;
    if (line_ctrl_reg.parity_en) begin // R12
      unique case (line_ctrl_reg.parity_sel)
        ULS_PAR_ODD: parity_bad = !(data_ones ^ rx_char.parity_bit); // R6
        ULS_PAR_EVEN: parity_bad = data_ones ^ rx_char.parity_bit; // R6
        ULS_PAR_STICK1: parity_bad = !rx_char.parity_bit; // R6
        ULS_PAR_STICK0: parity_bad = rx_char.parity_bit; // R6
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receive buffer
  // --------------------------------------------------------------------------
  // A full buffer refuses the push inside the FIFO, so the new byte is lost
  assign push_entry = '{parity_bad: parity_bad, // R8
                        data: rx_char.data & len_mask};
  assign push_ok = rx_char.valid && !fifo_full;
  assign overrun_event = rx_char.valid && fifo_full; // R4 R5

  uls_rx_fifo u_rx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(rx_flush_reg),
    .one_deep(!fifo_en_reg),
    .push(rx_char.valid),
    .push_entry(push_entry),
    .pop(rbr_read),
    .head(fifo_head),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // --------------------------------------------------------------------------
  // Line status flags
  // --------------------------------------------------------------------------
  // A new head shows up one cycle after a pop, or after a push into an empty buffer;
  // a pop of the last byte together with a push exposes the pushed byte as head
  assign head_new_next = (rbr_read && !fifo_empty &&
                          ((fifo_count > `ULS_CNT_ONE) || push_ok)) ||
                         (push_ok && fifo_empty); // R8

  always_ff @(posedge ref_clk) begin
    if (rst || rx_flush_reg) begin
      head_new_reg <= 1'b0;
    end else begin
      head_new_reg <= head_new_next;
    end
  end

  // With the FIFO on the error waits until its byte is at the head; off, at arrival
  assign parity_event = fifo_en_reg ?
                        (head_new_reg && !fifo_empty && fifo_head.parity_bad) : // R8 R9
                        (push_ok && parity_bad); // R9

  uls_sticky_flag u_overrun_flag (
    .ref_clk(ref_clk),
    .rst(rst), // R13
    .set(overrun_event), // R2
    .clr(lsr_read), // R3
    .flag(overrun_flag)
  );

  uls_sticky_flag u_parity_flag (
    .ref_clk(ref_clk),
    .rst(rst), // R13
    .set(parity_event), // R6
    .clr(lsr_read), // R7
    .flag(parity_error_flag)
  );

  assign rx_data_ready = !fifo_empty; // R1 R13

  // Bus writes have no path into this register
  always_comb begin
    line_status_reg = 8'h00; // R10
    line_status_reg[`ULS_LSR_DATA_READY] = rx_data_ready; // R1
    line_status_reg[`ULS_LSR_OVERRUN] = overrun_flag; // R2
    line_status_reg[`ULS_LSR_PARITY] = parity_error_flag; // R6
  end

  // --------------------------------------------------------------------------
  // Interrupt status, mask and output
  // --------------------------------------------------------------------------
  always_comb begin
    trig_level = `ULS_TRIG_L0;
    if (fifo_en_reg) begin
      unique case (trigger_reg)
        2'b00: trig_level = `ULS_TRIG_L0;
        2'b01: trig_level = `ULS_TRIG_L1;
        2'b10: trig_level = `ULS_TRIG_L2;
        2'b11: trig_level = `ULS_TRIG_L3;
      endcase
    end
  end

  assign level_hit = (fifo_count >= trig_level);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_hit_reg <= 1'b0;
    end else begin
      level_hit_reg <= level_hit;
    end
  end

  always_comb begin
    int_event = '0;
    int_event[`ULS_INT_RX] = push_ok;
    int_event[`ULS_INT_OVERRUN] = overrun_event;
    int_event[`ULS_INT_PARITY] = parity_event;
    int_event[`ULS_INT_TRIGGER] = level_hit && !level_hit_reg;
  end

  for (genvar i = 0; i < `ULS_INT_W; i++) begin : g_int
    uls_sticky_flag u_int_flag (
      .ref_clk(ref_clk),
      .rst(rst),
      .set(int_event[i]),
      .clr(isr_read),
      .flag(int_status[i])
    );
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_status & int_mask_reg);
    end
  end

  assign irq = irq_reg;
endmodule : uls_line_status

// ===== uls_map.svh
// Address map, field positions, reset values and sizes of the receive line status block
`ifndef ULS_MAP_SVH
`define ULS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ULS_ADDR_FIFO_CTRL 32'hE000_C008
`define ULS_ADDR_LINE_CTRL 32'hE000_C00C
`define ULS_ADDR_LINE_STATUS 32'hE000_C014
`define ULS_ADDR_RX_BUFFER 32'hE000_C040
`define ULS_ADDR_INT_STATUS 32'hE000_C044
`define ULS_ADDR_INT_MASK 32'hE000_C048

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ULS_LSR_DATA_READY 0
`define ULS_LSR_OVERRUN 1
`define ULS_LSR_PARITY 2
`define ULS_FCR_ENABLE 0
`define ULS_FCR_RX_RESET 1
`define ULS_FCR_TX_RESET 2
`define ULS_FCR_TRIG_LO 6
`define ULS_FCR_TRIG_HI 7
`define ULS_INT_RX 0
`define ULS_INT_OVERRUN 1
`define ULS_INT_PARITY 2
`define ULS_INT_TRIGGER 3
`define ULS_WB_LANE0 0

// ----------------------------------------------------------------------------
// Sizes, reset values and levels
// ----------------------------------------------------------------------------
`define ULS_INT_W 4
`define ULS_FIFO_DEPTH 16
`define ULS_PTR_W 4
`define ULS_CNT_W 5
`define ULS_LCR_RST 8'h00
`define ULS_FCR_RST 3'h0
`define ULS_MASK_RST 4'h0
`define ULS_CNT_ZERO 5'h00
`define ULS_CNT_ONE 5'h01
`define ULS_CNT_FULL 5'h10
`define ULS_TRIG_L0 5'h01
`define ULS_TRIG_L1 5'h04
`define ULS_TRIG_L2 5'h08
`define ULS_TRIG_L3 5'h0E
`define ULS_DATA_ZERO 32'h0000_0000

`endif

// ===== uls_pkg.sv
// Types shared by the receive line status block and its helpers
package uls_pkg;
  `include "uls_map.svh"

  typedef enum logic [1:0] {
    ULS_PAR_ODD = 2'b00,
    ULS_PAR_EVEN = 2'b01,
    ULS_PAR_STICK1 = 2'b10,
    ULS_PAR_STICK0 = 2'b11
  } uls_parity_sel_t;

  typedef enum logic [1:0] {
    ULS_LEN5 = 2'b00,
    ULS_LEN6 = 2'b01,
    ULS_LEN7 = 2'b10,
    ULS_LEN8 = 2'b11
  } uls_word_len_t;

  typedef struct packed {
    logic dlab;
    logic break_ctrl;
    uls_parity_sel_t parity_sel;
    logic parity_en;
    logic stop_bits;
    uls_word_len_t word_len;
  } uls_line_ctrl_t;

  typedef struct packed {
    logic [1:0] trigger;
    logic fifo_enable;
    logic tx_fifo_reset;
  } uls_fifo_ctrl_t;

  typedef struct packed {
    logic parity_bad;
    logic [7:0] data;
  } uls_rx_entry_t;

  typedef struct packed {
    logic valid;
    logic parity_bit;
    logic [7:0] data;
  } uls_rx_char_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } uls_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } uls_wb_rsp_t;
endpackage : uls_pkg

// ===== uls_sticky_flag.sv
// Sticky flag bit whose set beats a clear in the same cycle
`timescale 1ns/100ps
module uls_sticky_flag (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule : uls_sticky_flag

// ===== uls_rx_fifo.sv
// Receive buffer FIFO in flip-flops, with a one-deep holding mode
`timescale 1ns/100ps
`include "uls_map.svh"
module uls_rx_fifo (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic one_deep,
  input wire logic push,
  input uls_pkg::uls_rx_entry_t push_entry,
  input wire logic pop,
  output uls_pkg::uls_rx_entry_t head,
  output logic [`ULS_CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  import uls_pkg::*;

  uls_rx_entry_t mem_reg [`ULS_FIFO_DEPTH];
  logic [`ULS_PTR_W-1:0] rd_ptr_reg;
  logic [`ULS_PTR_W-1:0] wr_ptr_reg;
  logic push_ok;
  logic pop_ok;

  // With the FIFO off the buffer behaves as a single holding register
  assign full = one_deep ? (count >= `ULS_CNT_ONE) : (count == `ULS_CNT_FULL);
  assign empty = (count == `ULS_CNT_ZERO);
  assign push_ok = push && !full;
  assign pop_ok = pop && !empty;
  assign head = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push_ok) begin
      mem_reg[wr_ptr_reg] <= push_entry;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count <= `ULS_CNT_ZERO;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        count <= count + 1'b1;
      end else if (pop_ok && !push_ok) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : uls_rx_fifo

// ===== uls_line_status_assertions.sv
// Concurrent checks on the ports of the receive line status block
`timescale 1ns/100ps
`include "uls_map.svh"
module uls_line_status_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input uls_pkg::uls_wb_req_t wb_req,
  input uls_pkg::uls_wb_rsp_t wb_rsp,
  input uls_pkg::uls_rx_char_t rx_char,
  input uls_pkg::uls_line_ctrl_t line_ctrl,
  input uls_pkg::uls_fifo_ctrl_t fifo_ctrl,
  input wire logic irq
);
  import uls_pkg::*;
  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  logic take, stat_rd, other, fcr_wr;
  logic rd_stat_q, clean_q, have_q, none_q;
  logic [2:0] quiet;
  assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  assign stat_rd = take && !wb_req.we && wb_req.adr == `ULS_ADDR_LINE_STATUS;
  assign other = take && !stat_rd;
  assign fcr_wr = take && wb_req.we && wb_req.sel[0] && wb_req.adr == `ULS_ADDR_FIFO_CTRL;
  // Flags count as known clean only after a quiet spell, since parity is flagged late
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_stat_q <= 1'b0;
      clean_q <= 1'b1;
      have_q <= 1'b0;
      none_q <= 1'b1;
      quiet <= 3'h0;
    end else begin
      rd_stat_q <= stat_rd;
      clean_q <= !(rx_char.valid || other) && (clean_q || (stat_rd && quiet == 3'h7));
      have_q <= (have_q || rx_char.valid) && !other;
      none_q <= !rx_char.valid && (none_q || (fcr_wr && wb_req.dat[1]));
      quiet <= (rx_char.valid || other) ? 3'h0 : quiet + {2'b00, quiet != 3'h7};
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ack_after_take: assert property (take |=> wb_rsp.ack)
    else $error("no ack after a taken access");
  a_ack_only_taken: assert property (!take |=> !wb_rsp.ack)
    else $error("ack without a taken access");
  a_status_upper_zero: assert property (rd_stat_q |-> wb_rsp.dat[31:3] == 29'h0)
    else $error("status upper bits not zero");
  a_flags_cleared: assert property (stat_rd && clean_q |=> wb_rsp.dat[2:1] == 2'b00)
    else $error("error flags survived a status read");
  a_ready_after_char: assert property (stat_rd && have_q |=> wb_rsp.dat[0])
    else $error("data ready low with a byte held");
  a_empty_not_ready: assert property (stat_rd && none_q |=> !wb_rsp.dat[0])
    else $error("data ready high with buffer empty");
  a_enable_follows: assert property (fcr_wr |=> fifo_ctrl.fifo_enable == $past(wb_req.dat[0])
    && (fifo_ctrl.tx_fifo_reset || !$past(wb_req.dat[2])))
    else $error("fifo control write not applied");
  a_tx_pulse_single: assert property (fifo_ctrl.tx_fifo_reset |=> !fifo_ctrl.tx_fifo_reset)
    else $error("transmit reset pulse too long");
endmodule : uls_line_status_assertions

bind uls_line_status uls_line_status_assertions u_chk (
  .ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .rx_char(rx_char),
  .line_ctrl(line_ctrl), .fifo_ctrl(fifo_ctrl), .irq(irq)
);

// ===== uls_rx_partner.sv
// Remote transmitter model handing assembled characters to the receive port
`timescale 1ns/100ps
module uls_rx_partner (
  input wire logic ref_clk,
  output uls_pkg::uls_rx_char_t rx_char
);
  import uls_pkg::*;
  initial rx_char = '{valid: 1'b0, parity_bit: 1'b1, data: 8'hFF};
  // ---------------------------------------------------------------
  // One character per call; idle data is inverted so nothing stale looks valid
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic p, input int gap = 0);
    @(posedge ref_clk);
    rx_char <= '{valid: 1'b1, parity_bit: p, data: d};
    @(posedge ref_clk);
    rx_char <= '{valid: 1'b0, parity_bit: ~p, data: ~d};
    repeat (gap) @(posedge ref_clk);
  endtask : send
endmodule : uls_rx_partner

// ===== tb_uls_line_status.sv
// Self-checking testbench for the receive line status block
`timescale 1ns/100ps
`include "uls_map.svh"
module tb_uls_line_status;
  import uls_pkg::*;
  localparam logic [31:0] LS = `ULS_ADDR_LINE_STATUS;
  localparam logic [31:0] RB = `ULS_ADDR_RX_BUFFER;
  localparam logic [31:0] FC = `ULS_ADDR_FIFO_CTRL;
  localparam logic [31:0] LC = `ULS_ADDR_LINE_CTRL;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  uls_wb_req_t req = '0;
  uls_wb_rsp_t rsp;
  uls_rx_char_t rx_char;
  uls_line_ctrl_t line_ctrl;
  uls_fifo_ctrl_t fifo_ctrl;
  logic irq;
  logic [31:0] q;
  int mismatches = 0;
  int checks = 0;
  always #10 ref_clk = ~ref_clk;
  uls_line_status DUT (.ref_clk(ref_clk), .rst(rst), .wb_req(req), .wb_rsp(rsp),
    .rx_char(rx_char), .line_ctrl(line_ctrl), .fifo_ctrl(fifo_ctrl), .irq(irq));
  uls_rx_partner u_tx (.ref_clk(ref_clk), .rx_char(rx_char));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic [31:0] adr, input logic we, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h00_0000, d}};
    do @(posedge ref_clk); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask : wb
  // Upper bits are expected zero, as every register lives in the low byte
  task automatic rd_chk(input logic [31:0] adr, input string what, input logic [7:0] exp);
    wb(adr, 1'b0, 8'h00);
    check(what, q, {24'h00_0000, exp});
  endtask : rd_chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_ready;
    rd_chk(LS, "status after reset", 8'h00);
    rd_chk(LS + 32'h0000_003C, "unmapped read", 8'h00);
    wb(FC, 1'b1, 8'h01);
    check("fifo enable on", {31'h0, fifo_ctrl.fifo_enable}, 32'h0000_0001);
    wb(LC, 1'b1, 8'h03);
    u_tx.send(8'h5A, 1'b0, 3);
    rd_chk(LS, "ready", 8'h01);
    rd_chk(RB, "rx byte", 8'h5A);
    rd_chk(LS, "ready after pop", 8'h00);
  endtask : test_ready
  task automatic test_overrun;
    wb(`ULS_ADDR_INT_MASK, 1'b1, 8'h02);
    for (int i = 0; i < 16; i++) u_tx.send(i[7:0], 1'b0);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    u_tx.send(8'hEE, 1'b0);
    repeat (8) @(posedge ref_clk);
    check("irq on overrun", {31'h0, irq}, 32'h0000_0001);
    wb(LS, 1'b1, 8'h00);
    rd_chk(LS, "overrun set", 8'h03);
    rd_chk(LS, "overrun cleared", 8'h01);
    rd_chk(`ULS_ADDR_INT_STATUS, "int status", 8'h0B);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    for (int i = 0; i < 16; i++) rd_chk(RB, "kept byte", i[7:0]);
    rd_chk(LS, "drained", 8'h00);
  endtask : test_overrun
  task automatic test_one_deep;
    wb(FC, 1'b1, 8'h00);
    check("fifo enable off", {31'h0, fifo_ctrl.fifo_enable}, 32'h0000_0000);
    wb(LC, 1'b1, 8'h0B);
    check("line ctrl", {24'h00_0000, line_ctrl}, 32'h0000_000B);
    u_tx.send(8'h01, 1'b1);
    u_tx.send(8'h02, 1'b0);
    repeat (8) @(posedge ref_clk);
    rd_chk(LS, "one deep", 8'h07);
    rd_chk(RB, "held byte", 8'h01);
    rd_chk(LS, "one deep drained", 8'h00);
  endtask : test_one_deep
  task automatic test_parity;
    logic [7:0] d;
    logic good;
    wb(FC, 1'b1, 8'h01);
    for (int s = 0; s < 4; s++) begin
      d = 8'h35 + s[7:0];
      good = (s == 0) ? ~^d : (s == 1) ? ^d : (s == 2);
      wb(LC, 1'b1, {2'b00, s[1:0], 4'hB});
      u_tx.send(d, good);
      u_tx.send(d, ~good);
      repeat (8) @(posedge ref_clk);
      rd_chk(LS, "good head", 8'h01);
      rd_chk(RB, "good byte", d);
      repeat (5) @(posedge ref_clk);
      rd_chk(LS, "bad head", 8'h05);
      rd_chk(LS, "parity cleared", 8'h01);
      rd_chk(RB, "bad byte", d);
    end
    wb(LC, 1'b1, 8'h03);
    u_tx.send(8'h35, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd_chk(LS, "parity off", 8'h01);
    rd_chk(RB, "parity off byte", 8'h35);
    // Five-bit words: the parity covers only the low bits, upper bits are stored as zero
    wb(LC, 1'b1, 8'h08);
    check("line ctrl short", {24'h00_0000, line_ctrl}, 32'h0000_0008);
    u_tx.send(8'hE1, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd_chk(LS, "short word parity", 8'h01);
    rd_chk(RB, "short word byte", 8'h01);
  endtask : test_parity
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    test_ready();
    $display("ready test done");
    test_overrun();
    $display("overrun test done");
    test_one_deep();
    $display("one deep test done");
    test_parity();
    $display("parity test done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end
endmodule : tb_uls_line_status
